// *** hw/dual_timer_count_control.sv ***
// dual 16-bit timer counters with count-source and counter-clear control, APB slave
// assumes synchronous pin inputs, one-cycle match/capture event pulses per general register
//
// How it works
// - clear select picks free run, A/B/C/D, sync
// - sync clear follows other unit, needs sync bit
// - edge field: rising, falling, both; 11 banned
// - edge field acts only for enabled external source
// - source 101 counts external pin when enabled
// - sources 001..100 divide clock by 2,4,8,32
// - source 000 is clock or on-chip oscillator
// - control registers reset to zero
// - unit 1 register ignored in rsync, PWM3
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "dual_timer_defines.svh"
module dual_timer_count_control
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscillator_select_option_bit,
    input wire logic hoco_tick,
    input wire logic external_timer_clock_pin,
    input wire logic [3:0] match_event_unit0,
    input wire logic [3:0] match_event_unit1,
    output dual_timer_pkg::count_t unit_counter0,
    output dual_timer_pkg::count_t unit_counter1
);
    import dual_timer_pkg::*;

    logic [7:0] timer_control_unit0;
    logic [7:0] timer_control_unit1;
    logic [7:0] function_config;
    logic [`TMR_PRE_W-1:0] prescale;
    logic pin_prev;
    logic [7:0] eff_ctrl [2];
    logic [1:0] tick;
    logic [1:0] own_clear;
    logic [1:0] clear_hit;
    logic [1:0] run;
    logic [1:0] start;
    count_t count [2];
    logic [3:0] events [2];
    logic setup;
    logic wr_access;
    logic addr_ok;
    timer_mode_t mode;
    logic sync_operation_bit;
    logic ext_clock_enable_bit;
    logic timer_peripheral_enable_bit;
    logic rise;
    logic fall;
    logic unit1_follows;

    assign mode = timer_mode_t'(function_config[`TMR_CFG_MODE_LSB +: 3]);
    assign sync_operation_bit = function_config[`TMR_CFG_SYNC_BIT];
    assign ext_clock_enable_bit = function_config[`TMR_CFG_EXTEN_BIT];
    assign timer_peripheral_enable_bit = function_config[`TMR_CFG_PEREN_BIT];
    assign start[0] = function_config[`TMR_CFG_START0_BIT];
    assign start[1] = function_config[`TMR_CFG_START1_BIT];
    assign events[0] = match_event_unit0;
    assign events[1] = match_event_unit1;

    // zero-wait APB slave
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    always_comb
    begin
        unique case (paddr)
            `TMR_OFF_CTRL0, `TMR_OFF_CTRL1, `TMR_OFF_CFG: addr_ok = 1'b1;
            `TMR_OFF_CNT0, `TMR_OFF_CNT1: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup)
        begin
            unique case (paddr)
                `TMR_OFF_CTRL0: prdata <= {24'h000000, timer_control_unit0};
                `TMR_OFF_CTRL1: prdata <= {24'h000000, timer_control_unit1};
                `TMR_OFF_CFG: prdata <= {24'h000000, function_config};
                `TMR_OFF_CNT0: prdata <= {16'h0000, count[0]};
                `TMR_OFF_CNT1: prdata <= {16'h0000, count[1]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_control_unit0 <= `TMR_CTRL_RESET;
            timer_control_unit1 <= `TMR_CTRL_RESET;
            function_config <= `TMR_CFG_RESET;
        end
        else if (wr_access)
        begin
            if (paddr == `TMR_OFF_CTRL0)
                timer_control_unit0 <= pwdata[7:0];
            if (paddr == `TMR_OFF_CTRL1)
                timer_control_unit1 <= pwdata[7:0];
            if (paddr == `TMR_OFF_CFG)
                function_config <= pwdata[7:0];
        end
    end

    // free-running prescaler for the divided sources
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescale <= '0;
        else
            prescale <= prescale + 5'h01;
    end

    // external pin edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_prev <= 1'b0;
        else
            pin_prev <= external_timer_clock_pin;
    end
    assign rise = external_timer_clock_pin && !pin_prev;
    assign fall = !external_timer_clock_pin && pin_prev;

    // unit 1 borrows unit 0 setup
    assign unit1_follows = (mode == MODE_RSYNC_PWM) || (mode == MODE_PWM3);
    assign eff_ctrl[0] = timer_control_unit0;
    assign eff_ctrl[1] = unit1_follows ? timer_control_unit0 : timer_control_unit1;
    assign run[0] = timer_peripheral_enable_bit && start[0];
    assign run[1] = timer_peripheral_enable_bit && (unit1_follows ? start[0] : start[1]);

    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        count_src_t src;
        edge_sel_t edge_sel;
        clear_sel_t clr_sel;
        logic ext_tick;
        logic tick_l;
        logic clr_l;
        count_t cnt;
        assign tick[u] = tick_l;
        assign own_clear[u] = clr_l;
        assign count[u] = cnt;
        assign src = count_src_t'(eff_ctrl[u][`TMR_CTRL_SRC_LSB +: 3]);
        assign edge_sel = edge_sel_t'(eff_ctrl[u][`TMR_CTRL_EDGE_LSB +: 2]);
        assign clr_sel = clear_sel_t'(eff_ctrl[u][`TMR_CTRL_CLR_LSB +: 3]);

        always_comb
        begin
            ext_tick = 1'b0;
            if (src == SRC_EXT && ext_clock_enable_bit)
            begin
                unique case (edge_sel)
                    EDGE_RISE: ext_tick = rise;
                    EDGE_FALL: ext_tick = fall;
                    EDGE_BOTH: ext_tick = rise || fall;
                    EDGE_BAD: ext_tick = 1'b0;
                endcase
            end
        end

        always_comb
        begin
            unique case (src)
                SRC_FULL: tick_l = oscillator_select_option_bit ? hoco_tick : 1'b1;
                SRC_DIV2: tick_l = prescale[0];
                SRC_DIV4: tick_l = &prescale[1:0];
                SRC_DIV8: tick_l = &prescale[2:0];
                SRC_DIV32: tick_l = &prescale;
                SRC_EXT: tick_l = ext_tick;
                SRC_BAD6, SRC_BAD7: tick_l = 1'b0;
            endcase
        end

        always_comb
        begin
            unique case (clr_sel)
                CLR_A: clr_l = events[u][0];
                CLR_B: clr_l = events[u][1];
                CLR_C: clr_l = events[u][2];
                CLR_D: clr_l = events[u][3];
                CLR_NONE, CLR_SYNC, CLR_BAD4, CLR_BAD7: clr_l = 1'b0;
            endcase
        end

        assign clear_hit[u] = own_clear[u] ||
            (clr_sel == CLR_SYNC && sync_operation_bit && own_clear[1-u]);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt <= 16'h0000;
            else if (run[u] && clear_hit[u])
                cnt <= 16'h0000;
            else if (run[u] && tick_l)
                cnt <= cnt + 16'h0001;
        end
    end

    assign unit_counter0 = count[0];
    assign unit_counter1 = count[1];

    AST_CLEAR_ZERO:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[0] && own_clear[0] |=> count[0] == 16'h0000)
    else $error("unit 0 not cleared on selected event");

    AST_SYNC_CLEAR:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[0] && g_unit[0].clr_sel == CLR_SYNC && sync_operation_bit && own_clear[1]
        |=> count[0] == 16'h0000 && (!$past(run[1]) || count[1] == 16'h0000))
    else $error("sync clear did not follow other unit");

    AST_EDGE_FALL:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].ext_tick && g_unit[0].edge_sel == EDGE_FALL |-> $fell(external_timer_clock_pin))
    else $error("falling edge mode counted a non-falling edge");

    AST_EDGE_GATED:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].ext_tick |-> g_unit[0].src == SRC_EXT && ext_clock_enable_bit)
    else $error("edge counted without enabled pin source");

    AST_EXT_HOLD:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].src == SRC_EXT && !ext_clock_enable_bit && !own_clear[0]
        |=> $stable(count[0]))
    else $error("counter moved with pin source disabled");

    AST_DIV8_RATE:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].src == SRC_DIV8 && tick[0] |=> (!tick[0] || g_unit[0].src != SRC_DIV8) [*7])
    else $error("divide by 8 ticked early");

    AST_OSC_SOURCE:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].src == SRC_FULL |-> tick[0] == (oscillator_select_option_bit ? hoco_tick : 1'b1))
    else $error("undivided source wrong");

    AST_RESET_ZERO:
    assert property (@(posedge pclk)
        $past(!presetn) |-> timer_control_unit0 == 8'h00 && timer_control_unit1 == 8'h00)
    else $error("control register not zero after reset");

    AST_UNIT1_FOLLOWS:
    assert property (@(posedge pclk) disable iff (!presetn)
        unit1_follows |-> eff_ctrl[1] == timer_control_unit0 && run[1] == run[0])
    else $error("unit 1 register acted in follow mode");

    AST_ADVANCE:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[1] && tick[1] && !clear_hit[1] |=> count[1] == $past(count[1]) + 16'h0001)
    else $error("unit 1 did not advance by one");

    AST_UNIT0_ADVANCE:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[0] && tick[0] && !clear_hit[0] |=> count[0] == $past(count[0]) + 16'h0001)
    else $error("unit 0 did not advance by one");

    AST_CLEAR_BEATS_TICK:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[0] && clear_hit[0] && tick[0] |=> count[0] == 16'h0000)
    else $error("advance won over clear");

    AST_STOPPED_HOLD:
    assert property (@(posedge pclk) disable iff (!presetn)
        !run[0] |=> $stable(count[0]))
    else $error("stopped counter moved");

    AST_FREE_RUN:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[0] && g_unit[0].clr_sel == CLR_NONE && tick[0] |=> count[0] == $past(count[0]) + 16'h0001)
    else $error("free running counter was cleared");

    AST_EDGE_RISE:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].ext_tick && g_unit[0].edge_sel == EDGE_RISE |-> $rose(external_timer_clock_pin))
    else $error("rising edge mode counted a non-rising edge");

    AST_EDGE_BAD:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].edge_sel == EDGE_BAD |-> !g_unit[0].ext_tick)
    else $error("prohibited edge code counted");

    AST_UNIT1_EDGE_GATED:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[1].ext_tick |-> g_unit[1].src == SRC_EXT && ext_clock_enable_bit)
    else $error("unit 1 edge counted without enabled pin source");

    AST_DIV2_RATE:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].src == SRC_DIV2 && tick[0] |=> !tick[0] || g_unit[0].src != SRC_DIV2)
    else $error("divide by 2 ticked twice in a row");

    AST_BAD_SOURCE:
    assert property (@(posedge pclk) disable iff (!presetn)
        g_unit[0].src == SRC_BAD6 || g_unit[0].src == SRC_BAD7 |-> !tick[0])
    else $error("prohibited source ticked");

    AST_SYNC_NEEDS_BIT:
    assert property (@(posedge pclk) disable iff (!presetn)
        !sync_operation_bit |-> clear_hit[1] == own_clear[1])
    else $error("sync clear acted without sync bit");

    AST_UNIT1_SYNC_CLEAR:
    assert property (@(posedge pclk) disable iff (!presetn)
        run[1] && g_unit[1].clr_sel == CLR_SYNC && sync_operation_bit && own_clear[0]
        |=> count[1] == 16'h0000)
    else $error("unit 1 sync clear did not follow unit 0");

    AST_RESET_COUNT_ZERO:
    assert property (@(posedge pclk)
        $past(!presetn) |-> count[0] == 16'h0000 && count[1] == 16'h0000)
    else $error("counter not zero after reset");
endmodule : dual_timer_count_control

// *** hw/dual_timer_defines.svh ***
// register offsets, field positions, reset values for the dual timer control block
// assumes a 20-bit APB byte address and 32-bit data
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH
`define TMR_ADDR_W 20
`define TMR_OFF_CTRL0 20'hF0270
`define TMR_OFF_CTRL1 20'hF0280
`define TMR_OFF_CFG 20'hF0290
`define TMR_OFF_CNT0 20'hF02A0
`define TMR_OFF_CNT1 20'hF02A4
`define TMR_CTRL_RESET 8'h00
`define TMR_CFG_RESET 8'h00
`define TMR_CTRL_SRC_LSB 0
`define TMR_CTRL_EDGE_LSB 3
`define TMR_CTRL_CLR_LSB 5
`define TMR_CFG_MODE_LSB 0
`define TMR_CFG_SYNC_BIT 3
`define TMR_CFG_EXTEN_BIT 4
`define TMR_CFG_PEREN_BIT 5
`define TMR_CFG_START0_BIT 6
`define TMR_CFG_START1_BIT 7
`define TMR_PRE_W 5
`define TMR_CNT_W 16
`endif

// *** hw/dual_timer_pkg.sv ***
// types for the dual timer control block
// used by the single design module
package dual_timer_pkg;
    typedef enum logic [2:0] {
        CLR_NONE = 3'h0,
        CLR_A = 3'h1,
        CLR_B = 3'h2,
        CLR_SYNC = 3'h3,
        CLR_BAD4 = 3'h4,
        CLR_C = 3'h5,
        CLR_D = 3'h6,
        CLR_BAD7 = 3'h7
    } clear_sel_t;
    typedef enum logic [2:0] {
        SRC_FULL = 3'h0,
        SRC_DIV2 = 3'h1,
        SRC_DIV4 = 3'h2,
        SRC_DIV8 = 3'h3,
        SRC_DIV32 = 3'h4,
        SRC_EXT = 3'h5,
        SRC_BAD6 = 3'h6,
        SRC_BAD7 = 3'h7
    } count_src_t;
    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_BAD = 2'h3
    } edge_sel_t;
    typedef enum logic [2:0] {
        MODE_CAP_CMP = 3'h0,
        MODE_PWM = 3'h1,
        MODE_RSYNC_PWM = 3'h2,
        MODE_COMP_PWM = 3'h3,
        MODE_PWM3 = 3'h4
    } timer_mode_t;
    typedef logic [15:0] count_t;
endpackage : dual_timer_pkg

// *** test/tb_dual_timer_count_control.sv ***
// self-checking bench for the dual timer control block
// assumes a zero-wait APB slave and the map of the defines header
`timescale 1ns/1ns
`include "dual_timer_defines.svh"
module tb_dual_timer_count_control;
    import dual_timer_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_opt = 1'b0;
    logic hoco = 1'b0;
    logic pin = 1'b0;
    logic [3:0] match0 = 4'h0;
    logic [3:0] match1 = 4'h0;
    count_t unit_counter0;
    count_t unit_counter1;
    logic [7:0] cyc = 8'h0;
    logic [31:0] rdata;
    logic rerr;
    int bad_count = 0;
    int check_count = 0;
    int shift_by[5] = '{0, 1, 2, 3, 5};
    int edge_cnt[4] = '{8, 8, 16, 0};
    logic [2:0] clr_code[4] = '{3'h1, 3'h2, 3'h5, 3'h6};

    dual_timer_count_control dual_timer_count_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscillator_select_option_bit(osc_opt),
        .hoco_tick(hoco), .external_timer_clock_pin(pin),
        .match_event_unit0(match0), .match_event_unit1(match1),
        .unit_counter0(unit_counter0), .unit_counter1(unit_counter1)
    );

    always #4 pclk = ~pclk;

    // pin period 8 cycles, oscillator tick every 4th cycle
    always @(posedge pclk)
    begin
        cyc <= cyc + 8'h1;
        pin <= cyc[2];
        hoco <= (cyc[1:0] == 2'h0);
    end

    task automatic conclude;
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [19:0] a, input logic w, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            $display("unexpected at %0t: bus hang", $time);
            conclude();
        end
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdata, exp);
    endtask : rd_chk

    // counter growth over 64 cycles
    task automatic rate(input logic u, input logic [15:0] exp);
        count_t v;
        @(negedge pclk);
        v = u ? unit_counter1 : unit_counter0;
        repeat (64) @(posedge pclk);
        @(negedge pclk);
        chk({16'h0, (u ? unit_counter1 : unit_counter0) - v}, {16'h0, exp});
        @(posedge pclk);
    endtask : rate

    task automatic pulse(input int b, input logic u, input logic hit);
        {match1, match0} <= 8'h01 << b;
        @(posedge pclk);
        {match1, match0} <= 8'h00;
        #1;
        chk({31'h0, (u ? unit_counter1 : unit_counter0) === 16'h0}, {31'h0, hit});
        @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask : pulse

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`TMR_OFF_CTRL0, 32'h0);
        rd_chk(`TMR_OFF_CTRL1, 32'h0);
        wr(`TMR_OFF_CTRL1, 32'hA5);
        rd_chk(`TMR_OFF_CTRL1, 32'hA5);
        rd_chk(20'hF0300, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(`TMR_OFF_CFG, 32'h60);
        for (int i = 0; i < 5; i++)
        begin
            wr(`TMR_OFF_CTRL0, i);
            rate(1'b0, 16'(64 >> shift_by[i]));
        end
        wr(`TMR_OFF_CTRL0, 32'h0);
        osc_opt <= 1'b1;
        rate(1'b0, 16'h10);
        osc_opt <= 1'b0;
        wr(`TMR_OFF_CFG, 32'h70);
        for (int e = 0; e < 4; e++)
        begin
            wr(`TMR_OFF_CTRL0, {27'h0, 2'(e), 3'h5});
            rate(1'b0, 16'(edge_cnt[e]));
        end
        wr(`TMR_OFF_CTRL0, 32'h5);
        wr(`TMR_OFF_CFG, 32'h60);
        rate(1'b0, 16'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(`TMR_OFF_CTRL0, {24'h0, clr_code[c], 5'h0});
            for (int b = 0; b < 4; b++)
                pulse(b, 1'b0, b == c);
        end
        wr(`TMR_OFF_CTRL0, 32'h0);
        for (int b = 0; b < 4; b++)
            pulse(b, 1'b0, 1'b0);
        wr(`TMR_OFF_CTRL0, 32'h20);
        wr(`TMR_OFF_CTRL1, 32'h60);
        wr(`TMR_OFF_CFG, 32'hE8);
        pulse(0, 1'b1, 1'b1);
        wr(`TMR_OFF_CFG, 32'hE0);
        pulse(0, 1'b1, 1'b0);
        wr(`TMR_OFF_CTRL1, 32'h06);
        wr(`TMR_OFF_CFG, 32'h62);
        rate(1'b1, 16'h40);
        wr(`TMR_OFF_CFG, 32'hE0);
        rate(1'b1, 16'h0);
        wr(`TMR_OFF_CFG, 32'h64);
        rate(1'b1, 16'h40);
        wr(`TMR_OFF_CFG, 32'h61);
        pulse(0, 1'b0, 1'b1);
        wr(`TMR_OFF_CTRL0, 32'h0);
        wr(`TMR_OFF_CTRL1, 32'h0);
        wr(`TMR_OFF_CFG, 32'hE3);
        rate(1'b1, 16'h40);
        pulse(0, 1'b1, 1'b0);
        wr(`TMR_OFF_CTRL0, 32'h60);
        wr(`TMR_OFF_CTRL1, 32'h20);
        wr(`TMR_OFF_CFG, 32'hE8);
        pulse(4, 1'b0, 1'b1);
        conclude();
    end
endmodule : tb_dual_timer_count_control
